// ===== common/fault_map.svh
// Purpose: Register codes, field positions, reset values and delay decode for the fault retry block
// Assumes: Command codes are byte wide; register data is at most 16 bits
// Notes:   Shared by the controller, delay timer, host model and test bench
// What this block does
// RQ1: Retry settings 100, 101, 110 give exactly four, five, six restart attempts.
// RQ2: When every allowed attempt fails, output stays off until fault clears.
// RQ3: Attempt starts are spaced by retry-time count times the delay unit.
// RQ4: Setting 111 retries forever until commanded off, bias lost or other fault.
// RQ5: Three-bit time field counts delay units for run-on or retry spacing.
// RQ6: Time code 0 gives one unit, 2 two units, 3 eight units.
// RQ7: Time codes 4, 5, 6, 7 give 16, 32, 64, 128 units.
// RQ8: Length of one delay unit comes from the register at code 0xD2.
// RQ9: Sixteen-bit overvoltage warning threshold lives at command code 0x42.
// RQ10: Response field picks ignore, run-on then retry, shutdown retry, or hold off.
// RQ11: Retry setting 000 makes no attempt; output stays off until cleared.
// RQ12: Latched fault clears by host clear, off-then-on command, or bias loss.
// RQ13: Output above threshold raises a warning without disabling the output.
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH

`define CODE_CLEAR_FAULTS  8'h03
`define CODE_OV_WARN_THR   8'h42
`define CODE_FAULT_RESP    8'hd0
`define CODE_DELAY_UNIT    8'hd2
`define CODE_STATUS        8'he0

`define RESP_MODE_HI       7
`define RESP_MODE_LO       6
`define RESP_RETRY_HI      5
`define RESP_RETRY_LO      3
`define RESP_TIME_HI       2
`define RESP_TIME_LO       0

`define RETRY_NONE         3'h0
`define RETRY_FOREVER      3'h7

`define STAT_FAULT_BIT     0
`define STAT_WARN_BIT      1
`define STAT_OUT_BIT       2
`define STAT_LATCH_BIT     3
`define STAT_ATT_LO        4

`define RST_OV_WARN_THR    16'hffff
`define RST_FAULT_RESP     8'h80
`define RST_DELAY_UNIT     16'h0028

`define UNITS_CODE0        8'h01
`define UNITS_CODE1        8'h04
`define UNITS_CODE2        8'h02
`define UNITS_CODE3        8'h08
`define UNITS_CODE4        8'h10
`define UNITS_CODE5        8'h20
`define UNITS_CODE6        8'h40
`define UNITS_CODE7        8'h80

`endif

// ===== common/fault_pkg.sv
// Purpose: Types for the fault retry block
// Assumes: Nothing beyond the map header
// Notes:   Encodings left to the tools
package fault_pkg;

  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_RUN_ON,
    RESP_SHUT_RETRY,
    RESP_HOLD_OFF
  } resp_mode_t;

  typedef enum {
    ST_OFF,
    ST_RUN,
    ST_DELAY_RUN,
    ST_HOLD,
    ST_RETRY_WAIT,
    ST_ATTEMPT,
    ST_LATCHED
  } fault_state_t;

endpackage

// ===== hdl/delay_timer.sv
// Purpose: Counts a decoded number of delay units, each a programmable number of cycles
// Assumes: start is a single-cycle request; unit length zero is served as one cycle
// Notes:   done is a one-cycle pulse on the last counted cycle
`timescale 1ns/100ps
`include "fault_map.svh"
module delay_timer #(
  parameter int UNIT_W = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              start,
  input  wire logic [2:0]        time_code,
  input  wire logic [UNIT_W-1:0] unit_len,
  output logic                   done
);

  logic [UNIT_W-1:0] unit_cnt_reg, unit_cnt_next;
  logic [7:0]        left_reg,     left_next;
  logic              run_reg,      run_next;
  logic [UNIT_W-1:0] len_m1_reg,   len_m1_next;
  logic [7:0]        units;
  logic [UNIT_W-1:0] unit_m1;

  if (UNIT_W < 1 || UNIT_W > 24) begin : g_chk
    $error("delay_timer: UNIT_W out of range");
  end

  // RQ6 RQ7: time code decode
  always_comb begin
    case (time_code)
      3'h0:    units = `UNITS_CODE0;
      3'h1:    units = `UNITS_CODE1;
      3'h2:    units = `UNITS_CODE2;
      3'h3:    units = `UNITS_CODE3;
      3'h4:    units = `UNITS_CODE4;
      3'h5:    units = `UNITS_CODE5;
      3'h6:    units = `UNITS_CODE6;
      default: units = `UNITS_CODE7;
    endcase
  end

  // RQ8: unit length from register
  assign unit_m1 = (unit_len == '0) ? '0 : unit_len - UNIT_W'(1);
  assign done    = run_reg && unit_cnt_reg == '0 && left_reg == 8'h00;

  // Unit length held from start; a mid-delay write waits for the next start
  always_comb begin
    unit_cnt_next = unit_cnt_reg;
    left_next     = left_reg;
    run_next      = run_reg;
    len_m1_next   = len_m1_reg;
    if (start) begin
      unit_cnt_next = unit_m1;
      len_m1_next   = unit_m1;
      left_next     = units - 8'h01;
      run_next      = 1'b1;
    end else if (run_reg) begin
      if (unit_cnt_reg != '0) begin
        unit_cnt_next = unit_cnt_reg - UNIT_W'(1);
      end else if (left_reg != 8'h00) begin
        left_next     = left_reg - 8'h01;
        unit_cnt_next = len_m1_reg;
      end else begin
        run_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unit_cnt_reg <= '0;
      left_reg     <= 8'h00;
      run_reg      <= 1'b0;
      len_m1_reg   <= '0;
    end else if (ce) begin
      unit_cnt_reg <= unit_cnt_next;
      left_reg     <= left_next;
      run_reg      <= run_next;
      len_m1_reg   <= len_m1_next;
    end
  end

  // Elapsed enabled cycles since start, for checking only
  logic [31:0] elapsed_reg;
  logic [31:0] total;
  logic [UNIT_W-1:0] len_at_start_reg;
  logic [7:0]        units_at_start_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      elapsed_reg        <= 32'h0;
      len_at_start_reg   <= '0;
      units_at_start_reg <= 8'h00;
    end else if (ce) begin
      elapsed_reg <= start ? 32'h0 : elapsed_reg + 32'h1;
      if (start) begin
        len_at_start_reg   <= (unit_len == '0) ? UNIT_W'(1) : unit_len;
        units_at_start_reg <= units;
      end
    end
  end
  assign total = 32'(units_at_start_reg) * 32'(len_at_start_reg);

  property p_span;
    @(posedge clk) disable iff (srst) (ce && done) |-> elapsed_reg == total - 32'h1;
  endproperty
  a_span: assert property (p_span) else $error("delay span differs from units times unit length"); // RQ3

  property p_code7;
    @(posedge clk) disable iff (srst) (time_code == 3'h7) |-> units == 8'h80;
  endproperty
  a_code7: assert property (p_code7) else $error("code 7 not 128 units"); // RQ7

  property p_code3;
    @(posedge clk) disable iff (srst) (time_code == 3'h3) |-> units == 8'h08;
  endproperty
  a_code3: assert property (p_code3) else $error("code 3 not 8 units"); // RQ6

endmodule

// ===== hdl/ov_warn_cmp.sv
// Purpose: Compares measured output voltage with the warning threshold
// Assumes: Both values share one unsigned output-voltage format
// Notes:   Sticky flag; a new event beats a clear in the same cycle
`timescale 1ns/100ps
module ov_warn_cmp #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] vout_meas,
  input  wire logic [W-1:0] threshold,
  input  wire logic         clear,
  output logic              warn_level,
  output logic              warn_flag
);

  logic level_reg, level_next;
  logic flag_reg,  flag_next;

  if (W < 2) begin : g_chk
    $error("ov_warn_cmp: W too small");
  end

  // RQ13: warn only, never disables
  always_comb begin
    level_next = vout_meas > threshold;
    flag_next  = (flag_reg && !clear) || level_next;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      level_reg <= 1'b0;
      flag_reg  <= 1'b0;
    end else if (ce) begin
      level_reg <= level_next;
      flag_reg  <= flag_next;
    end
  end

  assign warn_level = level_reg;
  assign warn_flag  = flag_reg;

endmodule

// ===== hdl/fault_retry_ctrl.sv
// Purpose: Fault response and restart sequencing with its command registers
// Assumes: Command port is a byte-coded register access already decoded from the bus
// Notes:   One fault input per instance; on_cmd merges control pin and on/off command
`timescale 1ns/100ps
`include "fault_map.svh"
module fault_retry_ctrl #(
  parameter int UNIT_W = 16
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_ack,
  input  wire logic        fault_in,
  input  wire logic        other_shutdown,
  input  wire logic        on_cmd,
  input  wire logic        bias_ok,
  input  wire logic [15:0] vout_meas,
  output logic             out_enable,
  output logic             fault_latched,
  output logic             ov_warn
);

  logic [15:0]             thr_reg,     thr_next;
  logic [7:0]              resp_reg,    resp_next;
  logic [UNIT_W-1:0]       unit_reg,    unit_next;
  fault_pkg::fault_state_t state_reg,   state_next;
  logic [2:0]              att_reg,     att_next;
  logic                    flag_reg,    flag_next;
  logic                    out_reg,     out_next;
  logic [15:0]             rdata_reg,   rdata_next;
  logic                    ack_reg,     ack_next;

  logic                    wr;
  logic                    rd;
  logic                    clear_req;
  logic                    warn_clear;
  logic                    stop;
  logic                    tmr_start;
  logic                    tmr_done;
  logic                    warn_flag;
  logic                    exhausted;
  logic [15:0]             status;
  fault_pkg::resp_mode_t   mode;
  logic [2:0]              retry;

  if (UNIT_W < 1 || UNIT_W > 16) begin : g_chk
    $error("fault_retry_ctrl: UNIT_W must be 1 to 16");
  end

  assign mode  = fault_pkg::resp_mode_t'(resp_reg[`RESP_MODE_HI:`RESP_MODE_LO]);
  assign retry = resp_reg[`RESP_RETRY_HI:`RESP_RETRY_LO];
  assign wr    = cmd_valid && cmd_write;
  assign rd    = cmd_valid && !cmd_write;
  assign stop  = !on_cmd || !bias_ok || other_shutdown;

  // RQ12: host clear paths
  assign clear_req  = wr && (cmd_code == `CODE_CLEAR_FAULTS ||
                      (cmd_code == `CODE_STATUS && cmd_wdata[`STAT_FAULT_BIT]));
  assign warn_clear = wr && (cmd_code == `CODE_CLEAR_FAULTS ||
                      (cmd_code == `CODE_STATUS && cmd_wdata[`STAT_WARN_BIT]));

  // RQ1 RQ4: limit reached unless continuous
  assign exhausted = retry != `RETRY_FOREVER && att_reg >= retry;

  assign status = {9'h000, att_reg, (state_reg == fault_pkg::ST_LATCHED), out_reg, warn_flag, flag_reg};

  delay_timer #(
    .UNIT_W (UNIT_W)
  ) u_timer (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .start     (tmr_start),
    .time_code (resp_reg[`RESP_TIME_HI:`RESP_TIME_LO]),
    .unit_len  (unit_reg),
    .done      (tmr_done)
  );

  ov_warn_cmp #(
    .W (16)
  ) u_warn (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .vout_meas  (vout_meas),
    .threshold  (thr_reg),
    .clear      (warn_clear),
    .warn_level (ov_warn),
    .warn_flag  (warn_flag)
  );

  // Register file and command answers
  always_comb begin
    thr_next   = thr_reg;
    resp_next  = resp_reg;
    unit_next  = unit_reg;
    rdata_next = rdata_reg;
    ack_next   = cmd_valid;
    if (wr) begin
      case (cmd_code)
        // RQ9: warning threshold write
        `CODE_OV_WARN_THR: thr_next  = cmd_wdata;
        `CODE_FAULT_RESP:  resp_next = cmd_wdata[7:0];
        // RQ8: delay unit write
        `CODE_DELAY_UNIT:  unit_next = cmd_wdata[UNIT_W-1:0];
        default:           ;
      endcase
    end
    if (rd) begin
      case (cmd_code)
        `CODE_OV_WARN_THR: rdata_next = thr_reg;
        `CODE_FAULT_RESP:  rdata_next = {8'h00, resp_reg};
        `CODE_DELAY_UNIT:  rdata_next = 16'(unit_reg);
        `CODE_STATUS:      rdata_next = status;
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    att_next   = att_reg;
    tmr_start  = 1'b0;
    // Event beats a clear in the same cycle
    flag_next  = (flag_reg && !clear_req) || (fault_in && bias_ok);
    case (state_reg)
      fault_pkg::ST_OFF: begin
        if (!stop) begin
          state_next = fault_pkg::ST_RUN;
        end
        att_next = 3'h0;
      end
      fault_pkg::ST_RUN: begin
        if (fault_in) begin
          // RQ10: response selection
          case (mode)
            fault_pkg::RESP_IGNORE: ;
            fault_pkg::RESP_RUN_ON: begin
              state_next = fault_pkg::ST_DELAY_RUN;
              tmr_start  = 1'b1;
            end
            fault_pkg::RESP_SHUT_RETRY: begin
              // RQ11: no retry goes straight to latch
              state_next = (retry == `RETRY_NONE) ? fault_pkg::ST_LATCHED : fault_pkg::ST_RETRY_WAIT;
              tmr_start  = 1'b1;
              att_next   = 3'h0;
            end
            default: state_next = fault_pkg::ST_HOLD;
          endcase
        end
      end
      fault_pkg::ST_DELAY_RUN: begin
        // RQ5: run on for the delay, then act
        if (tmr_done) begin
          if (fault_in) begin
            state_next = (retry == `RETRY_NONE) ? fault_pkg::ST_LATCHED : fault_pkg::ST_RETRY_WAIT;
            tmr_start  = 1'b1;
            att_next   = 3'h0;
          end else begin
            state_next = fault_pkg::ST_RUN;
          end
        end
      end
      fault_pkg::ST_HOLD: begin
        if (!fault_in) begin
          state_next = fault_pkg::ST_RUN;
        end
      end
      fault_pkg::ST_RETRY_WAIT: begin
        // RQ3: next attempt starts on timer expiry
        if (tmr_done) begin
          state_next = fault_pkg::ST_ATTEMPT;
          tmr_start  = 1'b1;
          att_next   = (retry == `RETRY_FOREVER) ? att_reg : att_reg + 3'h1;
        end
      end
      fault_pkg::ST_ATTEMPT: begin
        if (fault_in) begin
          // RQ2: all attempts used, stay off
          if (exhausted) begin
            state_next = fault_pkg::ST_LATCHED;
          end else if (tmr_done) begin
            tmr_start = 1'b1;
            att_next  = (retry == `RETRY_FOREVER) ? att_reg : att_reg + 3'h1;
          end else begin
            state_next = fault_pkg::ST_RETRY_WAIT;
          end
        end else if (tmr_done) begin
          state_next = fault_pkg::ST_RUN;
        end
      end
      fault_pkg::ST_LATCHED: begin
        // RQ12: host clear releases the latch
        if (clear_req) begin
          state_next = fault_pkg::ST_OFF;
        end
      end
      default: state_next = fault_pkg::ST_OFF;
    endcase
    // RQ4 RQ12: off command, bias loss or other fault end any sequence
    if (stop) begin
      state_next = fault_pkg::ST_OFF;
      att_next   = 3'h0;
    end
    out_next = state_next == fault_pkg::ST_RUN || state_next == fault_pkg::ST_DELAY_RUN ||
               state_next == fault_pkg::ST_ATTEMPT;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      thr_reg   <= `RST_OV_WARN_THR;
      resp_reg  <= `RST_FAULT_RESP;
      unit_reg  <= UNIT_W'(`RST_DELAY_UNIT);
      state_reg <= fault_pkg::ST_OFF;
      att_reg   <= 3'h0;
      flag_reg  <= 1'b0;
      out_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
    end else if (ce) begin
      thr_reg   <= thr_next;
      resp_reg  <= resp_next;
      unit_reg  <= unit_next;
      state_reg <= state_next;
      att_reg   <= att_next;
      flag_reg  <= flag_next;
      out_reg   <= out_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  assign cmd_rdata     = rdata_reg;
  assign cmd_ack       = ack_reg;
  assign out_enable    = out_reg;
  assign fault_latched = state_reg == fault_pkg::ST_LATCHED;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_att_limit;
    (state_reg == fault_pkg::ST_ATTEMPT && retry != `RETRY_FOREVER) |-> att_reg <= retry && att_reg != 3'h0;
  endproperty
  a_att_limit: assert property (p_att_limit) else $error("attempt count beyond setting"); // RQ1

  property p_latched_off;
    (state_reg == fault_pkg::ST_LATCHED) |-> !out_enable;
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("output on while latched"); // RQ2

  property p_forever;
    (ce && state_reg == fault_pkg::ST_ATTEMPT && retry == `RETRY_FOREVER && fault_in && !stop)
      |=> state_reg != fault_pkg::ST_LATCHED;
  endproperty
  a_forever: assert property (p_forever) else $error("continuous retry latched"); // RQ4

  property p_ignore;
    (ce && state_reg == fault_pkg::ST_RUN && mode == fault_pkg::RESP_IGNORE && !stop)
      |=> state_reg == fault_pkg::ST_RUN && out_enable;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault changed state"); // RQ10

  property p_hold;
    (ce && state_reg == fault_pkg::ST_HOLD && !fault_in && !stop) |=> state_reg == fault_pkg::ST_RUN ##0 out_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("hold-off did not resume"); // RQ10

  property p_no_retry;
    (ce && state_reg == fault_pkg::ST_RUN && fault_in && mode == fault_pkg::RESP_SHUT_RETRY &&
     retry == `RETRY_NONE && !stop) |=> fault_latched && !out_enable;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retry 000 did not latch off"); // RQ11

  property p_clear;
    (ce && fault_latched && clear_req) |=> state_reg == fault_pkg::ST_OFF;
  endproperty
  a_clear: assert property (p_clear) else $error("latch not released by clear"); // RQ12

  property p_thr_wr;
    (ce && wr && cmd_code == `CODE_OV_WARN_THR) |=> thr_reg == $past(cmd_wdata);
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost"); // RQ9

  property p_warn;
    (ce && vout_meas > thr_reg) |=> ov_warn && warn_flag;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not raised"); // RQ13

  c_latch_after_tries: cover property (state_reg == fault_pkg::ST_ATTEMPT && retry == 3'h4 ##1 fault_latched);
  c_run_on_back:       cover property (state_reg == fault_pkg::ST_DELAY_RUN ##1 state_reg == fault_pkg::ST_RUN);
  c_forever_try:       cover property (state_reg == fault_pkg::ST_ATTEMPT && retry == `RETRY_FOREVER);

endmodule

// ===== tb/host_model.sv
// Purpose: Host side of the command port: reads, writes and sends
// Assumes: One request per call; ack lands on the same edge that takes it
// Notes:   Released lines carry inverted data so stale values never pass
`timescale 1ns/100ps
`include "fault_map.svh"
module host_model (
  input  wire logic        clk,
  input  wire logic        cmd_ack,
  input  wire logic [15:0] cmd_rdata,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Called just after an edge; an idle edge follows so valid never toggles twice in one step
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code  = code;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    ok = cmd_ack;
    rd = cmd_rdata;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~wd;
    @(posedge clk);
    #1;
  endtask

  task automatic send_clear(output logic ok);
    logic [15:0] d;
    xfer(1'b1, `CODE_CLEAR_FAULTS, 16'h0000, d, ok);
  endtask
endmodule

// ===== tb/fault_retry_response_control_test.sv
// Purpose: Self-checking bench for the fault retry controller
// Assumes: Host model drives the command port; ce held high except in the run-on freeze check
// Notes:   Unit length kept small so the longest retry spacing stays short
`timescale 1ns/100ps
`include "fault_map.svh"
module fault_retry_response_control_test;
  localparam int LIMIT = 40000;
  logic        clk, srst, fault_in, other_shutdown, on_cmd, bias_ok, ce;
  logic        cmd_valid, cmd_write, cmd_ack, out_enable, fault_latched, ov_warn, ok, p;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, vout_meas, thr, unit, d;
  logic [31:0] rng, r;
  int          err_total, cmp_count, cyc, n, a, k, c;
  int          units[$] = {1, 4, 2, 8, 16, 32, 64, 128};

  host_model host_u (.clk(clk), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid),
                     .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  fault_retry_ctrl dut_u (.clk(clk), .srst(srst), .ce(ce), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
                          .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
                          .cmd_ack(cmd_ack), .fault_in(fault_in), .other_shutdown(other_shutdown),
                          .on_cmd(on_cmd), .bias_ok(bias_ok), .vout_meas(vout_meas),
                          .out_enable(out_enable), .fault_latched(fault_latched), .ov_warn(ov_warn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      close_out();
    end
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] wd);
    host_u.xfer(1'b1, code, wd, d, ok);
    check("ack", {15'h0000, ok}, 16'h0001);
  endtask

  task automatic rdchk(input string name, input logic [7:0] code, input logic [15:0] exp);
    host_u.xfer(1'b0, code, 16'h0000, d, ok);
    check(name, d, exp);
  endtask

  // Cycles until the next rise of the output enable, capped at lim
  task automatic wait_rise(input int lim, output int cnt);
    logic q;
    q = out_enable;
    cnt = 0;
    while (cnt < lim && !(q === 1'b0 && out_enable === 1'b1)) begin
      q = out_enable;
      tick(1);
      cnt++;
    end
  endtask

  // Off then on clears any latch and starts from a clean run state
  task automatic restart();
    fault_in = 1'b0;
    other_shutdown = 1'b0;
    bias_ok = 1'b1;
    on_cmd = 1'b0;
    tick(3);
    on_cmd = 1'b1;
    tick(3);
  endtask

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    fault_in = 1'b0;
    other_shutdown = 1'b0;
    on_cmd = 1'b0;
    bias_ok = 1'b1;
    vout_meas = 16'h0000;
    rng = 32'hf9d7;
    tick(4);
    srst = 1'b0;
    check("out_rst", {15'h0000, out_enable}, 16'h0000);
    rdchk("thr_rst", `CODE_OV_WARN_THR, `RST_OV_WARN_THR);
    rdchk("resp_rst", `CODE_FAULT_RESP, {8'h00, `RST_FAULT_RESP});
    rdchk("unit_rst", `CODE_DELAY_UNIT, `RST_DELAY_UNIT);
    rdchk("unmapped", 8'h55, 16'h0000);
    restart();
    for (k = 0; k < 4; k++) begin
      r = rnd();
      thr = {1'b0, r[14:0]};
      wr(`CODE_OV_WARN_THR, thr);
      rdchk("thr", `CODE_OV_WARN_THR, thr);
      vout_meas = thr + 16'h0001;
      tick(2);
      check("warn_hi", {15'h0000, ov_warn}, 16'h0001);
      check("warn_out", {15'h0000, out_enable}, 16'h0001);
      vout_meas = thr;
      tick(2);
      check("warn_eq", {15'h0000, ov_warn}, 16'h0000);
    end
    // Sticky warning stays until written off; output still on
    rdchk("warn_flag", `CODE_STATUS, 16'h0006);
    wr(`CODE_STATUS, 16'h0002);
    rdchk("warn_clr", `CODE_STATUS, 16'h0004);
    // Spacing floor of three cycles keeps each attempt visible as a separate rise
    for (c = 0; c < 8; c++) begin
      r = rnd();
      unit = 16'(3 + r[1:0]);
      restart();
      wr(`CODE_DELAY_UNIT, unit);
      rdchk("unit", `CODE_DELAY_UNIT, unit);
      wr(`CODE_FAULT_RESP, {8'h00, 2'b10, 3'b111, 3'(c)});
      fault_in = 1'b1;
      wait_rise(3000, n);
      repeat (c == 0 ? 8 : 1) begin
        wait_rise(3000, n);
        check("gap", 16'(n), 16'(units[c] * unit));
      end
      check("forever", {15'h0000, fault_latched}, 16'h0000);
      other_shutdown = 1'b1;
      tick(2);
      check("stop_out", {15'h0000, out_enable}, 16'h0000);
      wait_rise(200, n);
      check("stop_hold", 16'(n), 16'd200);
    end
    wr(`CODE_DELAY_UNIT, 16'h0003);
    for (c = 0; c < 7; c++) begin
      restart();
      wr(`CODE_FAULT_RESP, {8'h00, 2'b10, 3'(c), 3'b000});
      fault_in = 1'b1;
      a = 0;
      for (k = 0; k < 2000 && fault_latched !== 1'b1; k++) begin
        p = out_enable;
        tick(1);
        if (p === 1'b0 && out_enable === 1'b1)
          a++;
      end
      check("attempts", 16'(a), 16'(c));
      tick(20);
      check("latch_out", {15'h0000, out_enable}, 16'h0000);
      host_u.xfer(1'b0, `CODE_STATUS, 16'h0000, d, ok);
      check("status", d & 16'h007d, 16'(c * 16 + 9));
      fault_in = 1'b0;
      case (c % 3)
        0: host_u.send_clear(ok);
        1: begin
          on_cmd = 1'b0;
          tick(3);
          on_cmd = 1'b1;
        end
        default: begin
          bias_ok = 1'b0;
          tick(3);
          bias_ok = 1'b1;
        end
      endcase
      tick(4);
      check("cleared", {15'h0000, out_enable}, 16'h0001);
      check("unlatched", {15'h0000, fault_latched}, 16'h0000);
    end
    restart();
    wr(`CODE_FAULT_RESP, 16'h0003);
    fault_in = 1'b1;
    tick(30);
    check("ignore", {15'h0000, out_enable}, 16'h0001);
    restart();
    wr(`CODE_FAULT_RESP, 16'h00c3);
    fault_in = 1'b1;
    tick(3);
    check("hold_off", {15'h0000, out_enable}, 16'h0000);
    fault_in = 1'b0;
    tick(3);
    check("hold_on", {15'h0000, out_enable}, 16'h0001);
    restart();
    wr(`CODE_FAULT_RESP, 16'h0043);
    fault_in = 1'b1;
    tick(5);
    fault_in = 1'b0;
    tick(30);
    check("run_back", {15'h0000, out_enable}, 16'h0001);
    check("run_back_latch", {15'h0000, fault_latched}, 16'h0000);
    fault_in = 1'b1;
    tick(20);
    check("run_on", {15'h0000, out_enable}, 16'h0001);
    // Disabled clock freezes the run-on delay
    ce = 1'b0;
    tick(10);
    check("frozen", {15'h0000, out_enable}, 16'h0001);
    ce = 1'b1;
    tick(10);
    check("run_off", {15'h0000, out_enable}, 16'h0000);
    check("run_latch", {15'h0000, fault_latched}, 16'h0001);
    close_out();
  end
endmodule
